// >>> rtl/spf_ctrl.sv
/*
  spf_ctrl: apb register, store/load arming windows, fuse/lock read, eeprom
  interlock and timed flash operations.
  Assumes the cpu gives one-cycle store/load pulses and the flash array returns
  its ordinary byte combinationally on flash_rd_data_i for the current pointer.
*/
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spf_ctrl
#(
  parameter int OP_CYCLES = spf_pkg::OP_CYC_DEF         // flash operation length in cycles
)(
  input  wire logic        clk_i,                       // 200 MHz system clock
  input  wire logic        rst_i,                       // power-on reset, async
  input  wire logic        sys_reset_i,                 // system reset, sync
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic      [31:0] prdata_o,
  output logic             pslverr_o,
  input  wire logic        store_req_i,                 // store instruction pulse
  input  wire logic        load_req_i,                  // load instruction pulse
  input  wire logic [15:0] z_ptr_i,                     // address pointer
  input  wire logic  [7:0] flash_rd_data_i,             // ordinary flash byte
  input  wire logic  [7:0] fuse_low_prog_i,             // 1 = cell programmed
  input  wire logic  [7:0] fuse_high_prog_i,
  input  wire logic  [7:0] fuse_ext_prog_i,
  input  wire logic  [7:0] lock_prog_i,
  input  wire logic        eeprom_write_busy_i,
  output logic       [7:0] load_data_o,                 // load destination value
  output logic             load_valid_o,
  output logic             page_erase_o,                // start pulses to array
  output logic             page_write_o,
  output logic             lock_write_o,
  output logic             buf_load_o,
  output logic             buf_clear_o,
  output logic             cpu_halt_o,
  output logic             flash_busy_o
);
  import spf_pkg::*;

  localparam int OPW = $clog2(OP_CYCLES + 1);           // width of operation timer

  typedef struct packed {
    logic [4:0]     cmd;                                // low five control bits
    logic [2:0]     win;                                // arming window countdown
    logic           op_active;                          // timed operation running
    logic [OPW-1:0] op_cnt;                             // cycles left in operation
    logic           pready;
    logic [31:0]    prdata;
    logic           pslverr;
    logic [7:0]     load_data;
    logic           load_valid;
    logic           erase_p;
    logic           write_p;
    logic           lockw_p;
    logic           bufload_p;
    logic           bufclr_p;
    logic           busy;
    logic [31:0]    op_len;                             // cycles the running operation has lasted
  } spf_state_type;

  spf_state_type st_reg;                                // registered state
  spf_state_type st_next;                               // next state

  // legal command decode, used for acceptance and for the checks
  function automatic logic is_legal_cmd(input logic [4:0] c);
    is_legal_cmd = (c == CMD_REENABLE) || (c == CMD_FUSELOCK) || (c == CMD_WRITE) ||
                   (c == CMD_ERASE) || (c == CMD_BUFLOAD);
  endfunction

  // fuse/lock byte by pointer; cells read inverted, programmed gives zero
  function automatic logic [7:0] fuse_select(input logic [1:0] z,
                                             input logic [7:0] fl, input logic [7:0] lk,
                                             input logic [7:0] fe, input logic [7:0] fh);
    unique case (z)
      Z_FUSE_LOW:  fuse_select = ~fl;
      Z_LOCK:      fuse_select = ~lk;
      Z_FUSE_EXT:  fuse_select = ~fe;
      Z_FUSE_HIGH: fuse_select = ~fh;
    endcase
  endfunction

  logic apb_setup;                                      // setup phase seen
  logic apb_done;                                       // access completes this edge
  logic wr_ctrl;                                        // control write completes
  logic armed;                                          // store window open
  logic read_armed;                                     // fuse/lock load window open
  logic flash_busy;                                     // eeprom or timed op busy
  logic [31:0] rd_word;                                 // read mux

  assign apb_setup  = psel_i && !penable_i;
  assign apb_done   = psel_i && penable_i && st_reg.pready;
  assign wr_ctrl    = apb_done && pwrite_i && (paddr_i == SPF_ADDR_CTRL);
  assign flash_busy = eeprom_write_busy_i || st_reg.op_active;
  assign armed      = st_reg.cmd[BIT_EN] && (st_reg.win != 3'h0) && !st_reg.op_active;
  // load window is the first three cycles of the four-cycle store window
  assign read_armed = armed && (st_reg.cmd == CMD_FUSELOCK) &&
                      (st_reg.win > (STORE_WIN - LOAD_WIN)) && !eeprom_write_busy_i;

  // register read mux; rww busy and reserved bits stay zero on this variant
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (paddr_i == SPF_ADDR_CTRL)
    begin
      rd_word[4:0]    = st_reg.cmd;
      rd_word[BIT_RWWB] = 1'b0;
    end
    else if (paddr_i == SPF_ADDR_STATUS)
    begin
      rd_word[BIT_ST_EEP]  = eeprom_write_busy_i;
      rd_word[BIT_ST_BUSY] = flash_busy;
    end
  end

  // next-state logic: apb, window, store, load, operation timer, system reset
  always_comb
  begin
    st_next            = st_reg;
    st_next.erase_p    = 1'b0;
    st_next.write_p    = 1'b0;
    st_next.lockw_p    = 1'b0;
    st_next.bufload_p  = 1'b0;
    st_next.bufclr_p   = 1'b0;
    st_next.load_valid = 1'b0;
    // zero-wait slave: answer is prepared in the setup cycle
    if (apb_setup)
    begin
      st_next.pready  = 1'b1;
      st_next.pslverr = (paddr_i != SPF_ADDR_CTRL) && (paddr_i != SPF_ADDR_STATUS);
      st_next.prdata  = rd_word;
    end
    else if (apb_done)
    begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
    end
    // window countdown; an unused window drops every bit
    if (st_reg.win != 3'h0 && !st_reg.op_active)
    begin
      st_next.win = st_reg.win - 3'h1;
      if (st_reg.win == 3'h1 && !store_req_i)           // a store on the last edge still takes
      begin
        st_next.cmd = CMD_RESET;
      end
    end
    // store instruction in the window
    if (store_req_i && armed)
    begin
      st_next.win = 3'h0;
      unique case (st_reg.cmd)
        CMD_ERASE, CMD_WRITE, CMD_FUSELOCK:
        begin
          // enable stays set while the array is busy, unless a system reset comes on this same store edge
          st_next.op_active = 1'b1;
          st_next.op_cnt    = OPW'(OP_CYCLES);
          st_next.erase_p   = (st_reg.cmd == CMD_ERASE);
          st_next.write_p   = (st_reg.cmd == CMD_WRITE);
          st_next.lockw_p   = (st_reg.cmd == CMD_FUSELOCK);
        end
        CMD_REENABLE:
        begin
          st_next.bufclr_p = 1'b1;
          st_next.cmd      = CMD_RESET;
        end
        default:
        begin
          st_next.bufload_p = 1'b1;
          st_next.cmd       = CMD_RESET;
        end
      endcase
    end
    // load instruction: fuse/lock byte when armed, else the ordinary byte
    if (load_req_i)
    begin
      st_next.load_valid = 1'b1;
      if (read_armed)
      begin
        st_next.load_data = fuse_select(z_ptr_i[1:0], fuse_low_prog_i, lock_prog_i,
                                        fuse_ext_prog_i, fuse_high_prog_i);
        st_next.cmd = CMD_RESET;
        st_next.win = 3'h0;
      end
      else
      begin
        st_next.load_data = flash_rd_data_i;
      end
    end
    // operation timer counts the calibrated time, then releases enable
    if (st_reg.op_active)
    begin
      if (st_reg.op_cnt == OPW'(1))
      begin
        st_next.op_active = 1'b0;
        st_next.cmd       = CMD_RESET;
      end
      st_next.op_cnt = st_reg.op_cnt - OPW'(1);
    end
    // control write, refused while anything is busy or code is illegal
    if (wr_ctrl && !flash_busy && is_legal_cmd(pwdata_i[4:0]))
    begin
      st_next.cmd = pwdata_i[4:0];
      st_next.win = STORE_WIN;
    end
    // system reset clears the arming but leaves a running operation alone
    if (sys_reset_i)
    begin
      st_next.win = 3'h0;
      if (!st_reg.op_active)
      begin
        st_next.cmd = CMD_RESET;
      end
    end
    st_next.busy = eeprom_write_busy_i || st_next.op_active;
    st_next.op_len = st_reg.op_active ? st_reg.op_len + 32'h1 : 32'h0;   // run length for the length check
  end

  // single state register; power-on reset only, so system reset cannot abort
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pready_o     = st_reg.pready;
  assign prdata_o     = st_reg.prdata;
  assign pslverr_o    = st_reg.pslverr;
  assign load_data_o  = st_reg.load_data;
  assign load_valid_o = st_reg.load_valid;
  assign page_erase_o = st_reg.erase_p;
  assign page_write_o = st_reg.write_p;
  assign lock_write_o = st_reg.lockw_p;
  assign buf_load_o   = st_reg.bufload_p;
  assign buf_clear_o  = st_reg.bufclr_p;
  assign cpu_halt_o   = st_reg.op_active;
  assign flash_busy_o = st_reg.busy;

  sequence s_read_armed_idle;
    $rose(st_reg.cmd == CMD_FUSELOCK) ##0 (!load_req_i && !store_req_i && !sys_reset_i && !wr_ctrl) [*4];
  endsequence
  property p_eep_block;
    @(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && eeprom_write_busy_i && !st_reg.cmd[BIT_EN] && !sys_reset_i) |=> !st_reg.cmd[BIT_EN];
  endproperty
  a_eep_block: assert property (p_eep_block) else $error("control write taken during eeprom write");
  property p_eep_read;
    @(posedge clk_i) disable iff (rst_i)
    (load_req_i && eeprom_write_busy_i) |=> (load_data_o == $past(flash_rd_data_i));
  endproperty
  a_eep_read: assert property (p_eep_read) else $error("fuse read not refused under eeprom write");
  property p_lock_read;
    @(posedge clk_i) disable iff (rst_i)
    (load_req_i && read_armed && z_ptr_i[1:0] == Z_LOCK) |=> (load_data_o == ~$past(lock_prog_i)) && !st_reg.cmd[BIT_EN];
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock byte read wrong");
  property p_fuse_read;
    @(posedge clk_i) disable iff (rst_i)
    (load_req_i && read_armed) |=> load_data_o == ~(($past(z_ptr_i[1:0]) == Z_FUSE_LOW) ? $past(fuse_low_prog_i) :
      ($past(z_ptr_i[1:0]) == Z_LOCK) ? $past(lock_prog_i) :
      ($past(z_ptr_i[1:0]) == Z_FUSE_EXT) ? $past(fuse_ext_prog_i) : $past(fuse_high_prog_i));
  endproperty
  a_fuse_read: assert property (p_fuse_read) else $error("fuse byte read wrong");
  property p_read_expire;
    @(posedge clk_i) disable iff (rst_i)
    s_read_armed_idle |=> !st_reg.cmd[BIT_EN] && !st_reg.cmd[BIT_SEL];
  endproperty
  a_read_expire: assert property (p_read_expire) else $error("read select did not auto-clear");
  property p_plain_load;
    @(posedge clk_i) disable iff (rst_i)
    (load_req_i && !st_reg.cmd[BIT_EN]) |=> load_valid_o && (load_data_o == $past(flash_rd_data_i));
  endproperty
  a_plain_load: assert property (p_plain_load) else $error("disarmed load not ordinary");
  property p_reset_keeps_op;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg.op_active && sys_reset_i && st_reg.op_cnt != OPW'(1)) |=> st_reg.op_active;
  endproperty
  a_reset_keeps_op: assert property (p_reset_keeps_op) else $error("system reset aborted flash op");
  property p_op_len;
    @(posedge clk_i) disable iff (rst_i)
    $fell(st_reg.op_active) |-> (st_reg.op_len == OP_CYCLES);
  endproperty
  a_op_len: assert property (p_op_len) else $error("flash op length wrong");
  property p_rww_zero;
    @(posedge clk_i) disable iff (rst_i)
    pready_o |-> !prdata_o[BIT_RWWB];
  endproperty
  a_rww_zero: assert property (p_rww_zero) else $error("rww busy read as one");
  property p_illegal;
    @(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && !is_legal_cmd(pwdata_i[4:0]) && st_reg.win == 3'h0 && !st_reg.op_active
     && !store_req_i && !load_req_i && !sys_reset_i) |=> $stable(st_reg.cmd);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal command took effect");
  property p_store_win;
    @(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && !flash_busy && is_legal_cmd(pwdata_i[4:0]) && !sys_reset_i)
      ##1 (!store_req_i && !load_req_i && !wr_ctrl && !sys_reset_i) [*4] |=> !st_reg.cmd[BIT_EN];
  endproperty
  a_store_win: assert property (p_store_win) else $error("store window not four cycles");
  property p_en_held;
    @(posedge clk_i) disable iff (rst_i)
    st_reg.op_active |-> st_reg.cmd[BIT_EN] && flash_busy_o;
  endproperty
  a_en_held: assert property (p_en_held) else $error("enable dropped during operation");
endmodule : spf_ctrl
`default_nettype wire

// >>> rtl/spf_pkg.sv
/*
  spf_pkg: constants for the self-program fuse/lock read and flash timing block.
  Assumes a 200 MHz clk_i and one aligned 32-bit word for each register.
*/
`default_nettype none
package spf_pkg;
  localparam logic [11:0] SPF_ADDR_CTRL   = 12'h000;   // prog_mem_ctrl_status
  localparam logic [11:0] SPF_ADDR_STATUS = 12'h004;   // busy flags, read only
  // field positions inside prog_mem_ctrl_status
  localparam int BIT_EN   = 0;                          // self_program_enable
  localparam int BIT_PGE  = 1;                          // page_erase_cmd
  localparam int BIT_PGW  = 2;                          // page_write_cmd
  localparam int BIT_SEL  = 3;                          // fuse_lock_read_select
  localparam int BIT_RRE  = 4;                          // rww_section_reenable
  localparam int BIT_RWWB = 6;                          // rww_section_busy
  localparam int BIT_ST_EEP  = 0;                       // status: eeprom_write_busy
  localparam int BIT_ST_BUSY = 1;                       // status: flash busy
  // command codes in the low five bits; all but CMD_RESET are accepted
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_FUSELOCK = 5'h09;
  localparam logic [4:0] CMD_WRITE    = 5'h05;
  localparam logic [4:0] CMD_ERASE    = 5'h03;
  localparam logic [4:0] CMD_BUFLOAD  = 5'h01;
  localparam logic [4:0] CMD_RESET    = 5'h00;
  // arming windows in cpu cycles
  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam logic [2:0] LOAD_WIN  = 3'h3;
  // pointer values in the fuse/lock read window
  localparam logic [1:0] Z_FUSE_LOW  = 2'h0;
  localparam logic [1:0] Z_LOCK      = 2'h1;
  localparam logic [1:0] Z_FUSE_EXT  = 2'h2;
  localparam logic [1:0] Z_FUSE_HIGH = 2'h3;
  // flash operation time, each operation on its own
  localparam int CLK_MHZ     = 200;
  localparam int OP_MIN_US   = 3700;                    // 3.7 ms
  localparam int OP_MAX_US   = 4500;                    // 4.5 ms
  localparam int OP_MIN_CYC  = OP_MIN_US * CLK_MHZ;     // least time, exact
  localparam int OP_MAX_CYC  = OP_MAX_US * CLK_MHZ;     // longest time, exact
  localparam int OP_CYC_DEF  = (OP_MIN_CYC + OP_MAX_CYC) / 2;
endpackage : spf_pkg
`default_nettype wire

// >>> sim/spf_cpu_model.sv
/*
  spf_cpu_model: cpu side of spf_ctrl, an apb master plus store/load pulses.
  Assumes its calls start right after a rising edge of clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module spf_cpu_model
  import spf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [11:0] paddr_o,
  output logic      [31:0] pwdata_o,
  output logic             store_o,
  output logic             load_o,
  output logic      [15:0] z_o
);
  // bus idle at time zero
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    store_o = 1'b0;
    load_o = 1'b0;
    z_o = 16'h0;
  end
  // one transfer; an idle edge first so a release is never overwritten
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // look at the answer where it has settled; it stands until the access edge
    do @(negedge clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    @(posedge clk_i);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
  // arm a command; a polite caller waits for eeprom and flash to go idle
  task automatic ctrl(input logic [4:0] c, input bit polite);
    logic [31:0] q;
    logic        e;
    if (polite)
    begin
      do xfer(1'b0, SPF_ADDR_STATUS, 32'h0, q, e); while (q[BIT_ST_EEP] !== 1'b0);
      do xfer(1'b0, SPF_ADDR_CTRL, 32'h0, q, e); while (q[BIT_EN] !== 1'b0 || q[BIT_RWWB] !== 1'b0);
    end
    xfer(1'b1, SPF_ADDR_CTRL, {27'h0, c}, q, e);
  endtask
  // one-cycle instruction pulse, starting at the edge where the call is made
  task automatic instr(input bit ld, input logic [15:0] z);
    z_o <= z;
    if (ld)
      load_o <= 1'b1;
    else
      store_o <= 1'b1;
    @(posedge clk_i);
    load_o <= 1'b0;
    store_o <= 1'b0;
  endtask
endmodule // spf_cpu_model
`default_nettype wire

// >>> sim/self_program_fuse_lock_read_tb_top.sv
/*
  self_program_fuse_lock_read_tb_top: self-checking bench for spf_ctrl.
  Assumes the cpu model above and a short flash operation length.
*/
`timescale 1ns/1ps
`default_nettype none
module self_program_fuse_lock_read_tb_top;
  import spf_pkg::*;
  localparam int OPC = 20;                // shortened flash operation
  logic        clk_i, rst_i, sys_reset_i, eep, psel, penable, pwrite, pready, pslverr;
  logic        store, load, load_valid, halt, busy, pe, pw, lw, bl, bc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] z;
  logic  [7:0] flash, load_data;
  logic  [7:0] fprog [4];                 // indexed by pointer value
  logic  [7:0] expq [$];                  // expected load results
  logic [19:0] pcv, expv;                 // pulse counts, one nibble each
  logic  [4:0] codes [5] = '{CMD_REENABLE, CMD_FUSELOCK, CMD_WRITE, CMD_ERASE, CMD_BUFLOAD};
  int          halt_cnt, bad_count, checks;
  spf_ctrl #(.OP_CYCLES(OPC)) spf_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .sys_reset_i(sys_reset_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .store_req_i(store), .load_req_i(load),
    .z_ptr_i(z), .flash_rd_data_i(flash), .fuse_low_prog_i(fprog[0]), .fuse_high_prog_i(fprog[3]),
    .fuse_ext_prog_i(fprog[2]), .lock_prog_i(fprog[1]), .eeprom_write_busy_i(eep),
    .load_data_o(load_data), .load_valid_o(load_valid), .page_erase_o(pe), .page_write_o(pw),
    .lock_write_o(lw), .buf_load_o(bl), .buf_clear_o(bc), .cpu_halt_o(halt), .flash_busy_o(busy));
  spf_cpu_model spf_cpu_model_inst (.clk_i(clk_i), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .store_o(store), .load_o(load), .z_o(z));
  // 200 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // 32-bit lfsr for fuse and flash patterns
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [32:0] exp);
    logic [31:0] q;
    logic        e;
    spf_cpu_model_inst.xfer(1'b0, a, 32'h0, q, e);
    check($sformatf("read %h", a), {e, q}, exp);
  endtask
  task automatic summarize;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // monitor: each load result takes the oldest note; also counts pulses and halt cycles
  // sampled on the falling edge, where every registered output has settled
  always @(negedge clk_i)
  begin
    if (rst_i === 1'b0)
    begin
      if (load_valid === 1'b1)
        check("load", load_data, expq.size() ? expq.pop_front() : 8'hxx);
      pcv <= pcv + {3'h0, bl, 3'h0, pe, 3'h0, pw, 3'h0, lw, 3'h0, bc};
      halt_cnt <= halt_cnt + int'(halt === 1'b1);
    end
  end
  // watchdog: a hang is cut short well beyond the expected run
  initial
  begin
    #50000;
    bad_count++;
    summarize();
  end
  // main sequence
  initial
  begin
    {sys_reset_i, eep, flash, pcv, expv, halt_cnt, bad_count, checks} = '0;
    fprog = '{8'h0, 8'h0, 8'h0, 8'h0};
    seed = 32'h00014c3b;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(SPF_ADDR_CTRL, 33'h0);
    rdchk(12'h0f0, 33'h100000000);
    // fuse/lock reads: armed in time, too late, and during an eeprom write
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      fprog[i % 4] <= seed[7:0];
      flash <= seed[15:8];
      // third group: even steps write while eeprom is busy, odd steps arm first and then go busy
      eep <= (i == 8 || i == 10);
      spf_cpu_model_inst.ctrl(CMD_FUSELOCK, !(i == 8 || i == 10));
      if (i / 4 == 1)
        repeat (3) @(posedge clk_i);
      if (i == 9 || i == 11)
        eep <= 1'b1;
      expq.push_back(i / 4 == 0 ? ~seed[7:0] : seed[15:8]);
      spf_cpu_model_inst.instr(1'b1, {14'h0, 2'(i % 4)});
      if (i / 4 == 2)
        rdchk(SPF_ADDR_STATUS, 33'h3);
      eep <= 1'b0;
      rdchk(SPF_ADDR_CTRL, 33'h0);
    end
    // every accepted command code, a system reset in mid-erase
    for (int k = 0; k < 5; k++)
    begin
      spf_cpu_model_inst.ctrl(codes[k], 1'b1);
      spf_cpu_model_inst.instr(1'b0, seed[15:0]);
      expv = expv + (20'h1 << (4 * k));
      rdchk(SPF_ADDR_CTRL, (k inside {[1:3]}) ? {28'h0, codes[k]} : 33'h0);
      if (k == 3)
      begin
        sys_reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_reset_i <= 1'b0;
        @(negedge clk_i);
        check("halt", halt, 1'b1);
        check("busy", busy, 1'b1);
        @(posedge clk_i);
      end
      check("pulses", pcv, expv);
    end
    // a code outside the list, then a store after the window ran out
    spf_cpu_model_inst.ctrl(5'h07, 1'b1);
    rdchk(SPF_ADDR_CTRL, 33'h0);
    spf_cpu_model_inst.ctrl(CMD_WRITE, 1'b1);
    repeat (4) @(posedge clk_i);
    rdchk(SPF_ADDR_CTRL, 33'h0);
    spf_cpu_model_inst.instr(1'b0, 16'h0);
    repeat (2) @(posedge clk_i);
    check("pulses", pcv, expv);
    check("halt cycles", halt_cnt, 3 * OPC);
    summarize();
  end
endmodule // self_program_fuse_lock_read_tb_top
`default_nettype wire
